// >>> design/umc_pkg.sv
// Package for the modem control block of the two-port serial unit.
// Assumes an 8-bit processor I/O register bus with byte addresses.
package umc_pkg;
   // Register addresses
   localparam logic [7:0] UMC_PORT0_MODEM_CONTROL_ADDR = 8'hC4;
   localparam logic [7:0] UMC_PORT1_MODEM_CONTROL_ADDR = 8'hD4;
   localparam logic [7:0] UMC_MODEM_CONTROL_RESET = 8'h00;
   localparam logic [7:0] UMC_MODEM_CONTROL_WMASK = 8'h7F;
   // Field positions
   localparam int UMC_BIT_TERM_READY = 0;
   localparam int UMC_BIT_REQ_SEND = 1;
   localparam int UMC_BIT_AUX_ONE = 2;
   localparam int UMC_BIT_AUX_TWO = 3;
   localparam int UMC_BIT_LOOPBACK = 4;
   localparam int UMC_BIT_MULTIDROP = 5;
   localparam int UMC_BIT_POLARITY = 6;
   // Modem status vector order: {carrier, ring, data_set_ready, clear_to_send}
   localparam int UMC_MS_CTS = 0;
   localparam int UMC_MS_DSR = 1;
   localparam int UMC_MS_RI = 2;
   localparam int UMC_MS_DCD = 3;
   // Parity kinds handed to the transmitter and receiver
   typedef enum logic [1:0] {
      UMC_PAR_ODD = 2'h0,
      UMC_PAR_EVEN = 2'h1,
      UMC_PAR_SPACE = 2'h2,
      UMC_PAR_MARK = 2'h3
   } umc_parity_e;
endpackage : umc_pkg

// >>> design/umc_port.sv
// One port's modem control register and its loopback routing.
// Assumes synchronised pin inputs and same-clock internal signals.
`timescale 1ns/1ps
module umc_port
   import umc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Register access
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] modem_control_reg,
   // Parity setting from line control
   input wire logic parity_select_in,
   input wire logic first_char_sent,
   output logic parity_select_clear,
   output umc_parity_e parity_kind,
   // Serial data
   input wire logic tx_internal,
   input wire logic rx_pin_sync,
   output logic tx_pin,
   output logic rx_internal,
   // Modem lines
   input wire logic [3:0] modem_status_pin_sync,
   output logic [3:0] modem_status_internal,
   output logic req_send_n,
   output logic term_ready_n,
   output logic aux_one_n,
   output logic aux_two_n
);
   logic loop_on;
   logic pol;
   logic sel_done;

   ////////////////////////////////////////////////////////////////////////
   // Register, bit 7 held at zero
   always_ff @(posedge core_clk)
   begin
      if (rst)
         modem_control_reg <= UMC_MODEM_CONTROL_RESET;
      else if (wr_en)
         modem_control_reg <= wr_data & UMC_MODEM_CONTROL_WMASK;
   end

   assign loop_on = modem_control_reg[UMC_BIT_LOOPBACK];
   assign pol = modem_control_reg[UMC_BIT_POLARITY];

   ////////////////////////////////////////////////////////////////////////
   // Parity kind and multidrop select auto-clear
   always_comb
   begin
      if (modem_control_reg[UMC_BIT_MULTIDROP])
         parity_kind = parity_select_in ? UMC_PAR_MARK : UMC_PAR_SPACE;
      else
         parity_kind = parity_select_in ? UMC_PAR_EVEN : UMC_PAR_ODD;
   end

   // One clear pulse after the first character in multidrop
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         parity_select_clear <= 1'b0;
         sel_done <= 1'b0;
      end
      else
      begin
         parity_select_clear <= modem_control_reg[UMC_BIT_MULTIDROP] && first_char_sent
            && parity_select_in && !sel_done;
         if (!modem_control_reg[UMC_BIT_MULTIDROP] || !parity_select_in)
            sel_done <= 1'b0;
         else if (first_char_sent)
            sel_done <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers, all registered
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         tx_pin <= 1'b1;
         req_send_n <= 1'b1;
         term_ready_n <= 1'b1;
         aux_one_n <= 1'b1;
         aux_two_n <= 1'b1;
      end
      else if (loop_on)
      begin
         tx_pin <= 1'b1;
         req_send_n <= 1'b1;
         term_ready_n <= 1'b1;
         aux_one_n <= 1'b1;
         aux_two_n <= 1'b1;
      end
      else
      begin
         tx_pin <= tx_internal ^ pol;
         req_send_n <= ~modem_control_reg[UMC_BIT_REQ_SEND];
         term_ready_n <= ~modem_control_reg[UMC_BIT_TERM_READY];
         aux_one_n <= 1'b1; // No function outside loopback
         aux_two_n <= 1'b1; // No function outside loopback
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Internal receive data and modem status routing
   always_comb
   begin
      if (loop_on)
      begin
         rx_internal = tx_internal;
         modem_status_internal[UMC_MS_DCD] = modem_control_reg[UMC_BIT_AUX_TWO];
         modem_status_internal[UMC_MS_RI] = modem_control_reg[UMC_BIT_AUX_ONE];
         modem_status_internal[UMC_MS_CTS] = modem_control_reg[UMC_BIT_REQ_SEND];
         modem_status_internal[UMC_MS_DSR] = modem_control_reg[UMC_BIT_TERM_READY];
      end
      else
      begin
         rx_internal = rx_pin_sync ^ pol;
         modem_status_internal = modem_status_pin_sync;
      end
   end
endmodule : umc_port

// >>> design/umc_top.sv
// Modem control logic for both serial ports, reached over the I/O bus.
// Assumes pins arrive asynchronously and the rest of the unit shares core_clk.
`timescale 1ns/1ps
module umc_top
   import umc_pkg::*;
#(
   parameter int NUM_PORTS = 2
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // I/O register bus
   input wire logic [7:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_hit,
   // Line control interface, per port
   input wire logic [NUM_PORTS-1:0] parity_select_in,
   input wire logic [NUM_PORTS-1:0] first_char_sent,
   output logic [NUM_PORTS-1:0] parity_select_clear,
   output logic [2*NUM_PORTS-1:0] parity_kind,
   // Serial data, per port
   input wire logic [NUM_PORTS-1:0] tx_internal,
   output logic [NUM_PORTS-1:0] rx_internal,
   input wire logic [NUM_PORTS-1:0] rx_pin,
   output logic [NUM_PORTS-1:0] tx_pin,
   // Modem lines, per port
   input wire logic [4*NUM_PORTS-1:0] modem_status_pin,
   output logic [4*NUM_PORTS-1:0] modem_status_internal,
   output logic [NUM_PORTS-1:0] req_send_n,
   output logic [NUM_PORTS-1:0] term_ready_n,
   output logic [NUM_PORTS-1:0] aux_one_n,
   output logic [NUM_PORTS-1:0] aux_two_n
);
   localparam logic [7:0] PORT_ADDR [2] =
      '{UMC_PORT0_MODEM_CONTROL_ADDR, UMC_PORT1_MODEM_CONTROL_ADDR};

   logic [NUM_PORTS-1:0] rx_meta;
   logic [NUM_PORTS-1:0] rx_sync;
   logic [4*NUM_PORTS-1:0] ms_meta;
   logic [4*NUM_PORTS-1:0] ms_sync;
   logic [7:0] reg_val [NUM_PORTS];
   logic [NUM_PORTS-1:0] sel;
   logic [7:0] next_rdata;

   ////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers for pin inputs
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         rx_meta <= '1;
         rx_sync <= '1;
         ms_meta <= '0;
         ms_sync <= '0;
      end
      else
      begin
         rx_meta <= rx_pin;
         rx_sync <= rx_meta;
         ms_meta <= modem_status_pin;
         ms_sync <= ms_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-port register and routing
   for (genvar p = 0; p < NUM_PORTS; p++)
   begin : g_port
      umc_parity_e kind;
      assign sel[p] = (io_addr == PORT_ADDR[p]);
      assign parity_kind[2*p +: 2] = kind;
      umc_port u_port (
         .core_clk(core_clk),
         .rst(rst),
         .wr_en(io_wr && sel[p]),
         .wr_data(io_wdata),
         .modem_control_reg(reg_val[p]),
         .parity_select_in(parity_select_in[p]),
         .first_char_sent(first_char_sent[p]),
         .parity_select_clear(parity_select_clear[p]),
         .parity_kind(kind),
         .tx_internal(tx_internal[p]),
         .rx_pin_sync(rx_sync[p]),
         .tx_pin(tx_pin[p]),
         .rx_internal(rx_internal[p]),
         .modem_status_pin_sync(ms_sync[4*p +: 4]),
         .modem_status_internal(modem_status_internal[4*p +: 4]),
         .req_send_n(req_send_n[p]),
         .term_ready_n(term_ready_n[p]),
         .aux_one_n(aux_one_n[p]),
         .aux_two_n(aux_two_n[p])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped addresses read zero
   always_comb
   begin
      next_rdata = '0;
      for (int i = 0; i < NUM_PORTS; i++)
         if (sel[i])
            next_rdata = reg_val[i]; // Bit 7 is always zero
   end

   // Registered read data and address-hit flag
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         io_rdata <= '0;
         io_hit <= 1'b0;
      end
      else
      begin
         io_rdata <= io_rd ? next_rdata : 8'h00;
         io_hit <= (io_rd || io_wr) && (|sel);
      end
   end
endmodule : umc_top

// >>> tb/umc_top_chk.sv
// Assertions on port 0 of the modem control block.
// Assumes a bind into umc_top; one clock, synchronous reset.
`timescale 1ns/1ps
module umc_top_chk #(parameter int NUM_PORTS = 2)
(
   // Clock, reset and bus
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic io_hit,
   // Port lines
   input wire logic [NUM_PORTS-1:0] parity_select_in,
   input wire logic [2*NUM_PORTS-1:0] parity_kind,
   input wire logic [NUM_PORTS-1:0] tx_internal,
   input wire logic [NUM_PORTS-1:0] rx_internal,
   input wire logic [NUM_PORTS-1:0] rx_pin,
   input wire logic [NUM_PORTS-1:0] tx_pin,
   input wire logic [4*NUM_PORTS-1:0] modem_status_internal,
   input wire logic [NUM_PORTS-1:0] req_send_n,
   input wire logic [NUM_PORTS-1:0] term_ready_n
);
   logic [7:0] mc0;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Shadow of the port 0 register
   always_ff @(posedge core_clk)
   begin
      if (rst)
         mc0 <= 8'h00;
      else if (io_wr && io_addr == 8'hC4)
         mc0 <= io_wdata & 8'h7F;
   end
   // Pin checks start only at edges where reset was sampled low
   AST_RD_VAL: assert property (io_rd && io_addr == 8'hC4 && !rst |=>
      io_hit && io_rdata == $past(mc0)) else $error("read of port 0 register wrong");
   AST_TX_LOOP: assert property (mc0[4] && !rst |=> tx_pin[0])
      else $error("transmit pin not held high in loopback");
   AST_TX_NORM: assert property (!mc0[4] && !rst |=>
      tx_pin[0] == ($past(tx_internal[0]) ^ $past(mc0[6])))
      else $error("transmit pin wrong in normal mode");
   AST_RX_LOOP: assert property (mc0[4] |-> rx_internal[0] == tx_internal[0])
      else $error("receiver not fed from transmitter");
   AST_RX_NORM: assert property (!mc0[4] && !$past(rst) && !$past(rst, 2) |->
      rx_internal[0] == ($past(rx_pin[0], 2) ^ mc0[6])) else $error("receive path wrong");
   AST_MS_LOOP: assert property (mc0[4] |->
      modem_status_internal[3:0] == {mc0[3], mc0[2], mc0[0], mc0[1]}) else $error("status wrong");
   AST_HS_PINS: assert property (!rst |=>
      {req_send_n[0], term_ready_n[0]} == ($past(mc0[4]) ? 2'h3 : ~$past(mc0[1:0])))
      else $error("handshake pins wrong");
   AST_PARITY: assert property (parity_kind[1:0] == {mc0[5], parity_select_in[0]})
      else $error("parity kind wrong");
endmodule : umc_top_chk
////////////////////////////////////////////////////////////////////////////////
bind umc_top umc_top_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (.core_clk, .rst, .io_addr, .io_wr,
   .io_rd, .io_wdata, .io_rdata, .io_hit, .parity_select_in, .parity_kind, .tx_internal,
   .rx_internal, .rx_pin, .tx_pin, .modem_status_internal, .req_send_n, .term_ready_n);

// >>> tb/umc_remote_modem.sv
// Remote modem on the pins of both ports.
// Assumes the bench clock; lines change just after rising edges.
`timescale 1ns/1ps
module umc_remote_modem
(
   // Clock and handshake from the block
   input wire logic core_clk,
   input wire logic [1:0] req_send_n,
   input wire logic [1:0] term_ready_n,
   // Lines to the block
   output logic [1:0] rx_pin,
   output logic [7:0] modem_status_pin
);
   logic [7:0] noise = 8'hA5;
   // Line noise every cycle; handshake answered one cycle late
   always @(posedge core_clk)
   begin
      noise <= {noise[6:0], noise[7] ^ noise[5] ^ noise[4] ^ noise[3]};
      rx_pin <= noise[1:0];
      modem_status_pin <= {noise[3:2], ~term_ready_n[1], ~req_send_n[1],
         noise[5:4], ~term_ready_n[0], ~req_send_n[0]};
   end
endmodule : umc_remote_modem

// >>> tb/uart_modem_control_loopback_tb.sv
// Bench for the modem control block with a remote modem on the pins.
// Assumes a 100 MHz core clock and synchronous reset.
`timescale 1ns/1ps
module uart_modem_control_loopback_tb import umc_pkg::*;;
   logic core_clk = 1'b0, rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0, io_hit;
   logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata, modem_status_pin;
   logic [7:0] modem_status_internal;
   logic [3:0] parity_kind;
   logic [1:0] parity_select_in = 2'h0, first_char_sent = 2'h0, tx_internal = 2'h0;
   logic [1:0] rx_internal, rx_pin, tx_pin, parity_select_clear;
   logic [1:0] req_send_n, term_ready_n, aux_one_n, aux_two_n;
   logic [1:0] tx_prev, rx_d1, rx_d2;
   logic [7:0] ms_d1, ms_d2;
   int errors = 0, checks_done = 0, p;
   int mc [2] = '{0, 0};
   umc_top u_dut (.core_clk, .rst, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .io_hit,
      .parity_select_in, .first_char_sent, .parity_select_clear, .parity_kind, .tx_internal,
      .rx_internal, .rx_pin, .tx_pin, .modem_status_pin, .modem_status_internal,
      .req_send_n, .term_ready_n, .aux_one_n, .aux_two_n);
   umc_remote_modem u_modem (.core_clk, .req_send_n, .term_ready_n, .rx_pin, .modem_status_pin);
   always #5 core_clk = ~core_clk;
   // Transmitter output redrawn at random every cycle; pin history for expected values
   always @(posedge core_clk)
   begin
      tx_prev <= tx_internal;
      tx_internal <= 2'($urandom);
      rx_d1 <= rx_pin;
      rx_d2 <= rx_d1;
      ms_d1 <= modem_status_pin;
      ms_d2 <= ms_d1;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic h);
      @(posedge core_clk);
      io_rd <= 1'b1;
      io_addr <= a;
      @(posedge core_clk);
      io_rd <= 1'b0;
      @(negedge core_clk);
      chk(io_rdata, exp);
      chk(8'(io_hit), 8'(h));
   endtask : rd
   task automatic wr(input int q, input logic [7:0] d);
      @(posedge core_clk);
      io_wr <= 1'b1;
      io_addr <= q ? UMC_PORT1_MODEM_CONTROL_ADDR : UMC_PORT0_MODEM_CONTROL_ADDR;
      io_wdata <= d;
      @(posedge core_clk);
      io_wr <= 1'b0;
      mc[q] = d & 8'h7F;
      @(negedge core_clk);
      chk(8'(io_hit), 8'h01);
      chk(io_rdata, 8'h00);
   endtask : wr
   task automatic pins(input int q);
      logic [7:0] hs_exp;
      logic [7:0] ms_exp;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      hs_exp = mc[q][4] ? 8'h03 : 8'(~mc[q] & 3);
      ms_exp = 8'({mc[q][3], mc[q][2], mc[q][0], mc[q][1]});
      chk(8'({aux_one_n[q], aux_two_n[q]}), 8'h03);
      chk(8'({req_send_n[q], term_ready_n[q]}), hs_exp);
      if (mc[q][4])
      begin
         chk(8'(tx_pin[q]), 8'h01);
         chk(8'(rx_internal[q]), 8'(tx_internal[q]));
         chk(8'(modem_status_internal[4*q +: 4]), ms_exp);
      end
      else
      begin
         chk(8'(tx_pin[q]), 8'(tx_prev[q] ^ mc[q][6]));
         chk(8'(rx_internal[q]), 8'(rx_d2[q] ^ mc[q][6]));
         chk(8'(modem_status_internal[4*q +: 4]), 8'(ms_d2[4*q +: 4]));
      end
   endtask : pins
   task automatic mdrop(input int q);
      @(posedge core_clk);
      parity_select_in[q] <= 1'b1;
      first_char_sent[q] <= 1'b1;
      @(posedge core_clk);
      first_char_sent[q] <= 1'b0;
      @(negedge core_clk);
      chk(8'(parity_select_clear[q]), 8'(mc[q][5]));
      chk(8'(parity_kind[2*q +: 2]), 8'({mc[q][5], 1'b1}));
      // Second character with select still high must not clear again
      @(posedge core_clk);
      first_char_sent[q] <= 1'b1;
      @(negedge core_clk);
      chk(8'(parity_select_clear[q]), 8'h00);
      @(posedge core_clk);
      first_char_sent[q] <= 1'b0;
      parity_select_in[q] <= 1'b0;
      @(negedge core_clk);
      chk(8'(parity_select_clear[q]), 8'h00);
      chk(8'(parity_kind[2*q +: 2]), 8'({mc[q][5], 1'b0}));
   endtask : mdrop
   task automatic complete_run;
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run
   // Main sequence
   initial
   begin
      void'($urandom(47));
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      rd(UMC_PORT0_MODEM_CONTROL_ADDR, 8'h00, 1'b1);
      rd(UMC_PORT1_MODEM_CONTROL_ADDR, 8'h00, 1'b1);
      rd(8'hC5, 8'h00, 1'b0);
      for (int i = 0; i < 32; i++)
      begin
         p = $urandom % 2;
         wr(p, 8'($urandom));
         rd(p ? 8'hD4 : 8'hC4, 8'(mc[p]), 1'b1);
         pins(p);
         mdrop(p);
      end
      // Mid-run reset returns register and pins to idle
      wr(1, 8'h7F);
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      mc = '{0, 0};
      rd(UMC_PORT1_MODEM_CONTROL_ADDR, 8'h00, 1'b1);
      pins(1);
      complete_run();
   end
   // Watchdog
   initial
   begin
      #100us;
      errors++;
      complete_run();
   end
endmodule : uart_modem_control_loopback_tb
